/* File: hdl/mmu_control_registers.sv */
// Control and status registers of the processor memory management unit.
//
// Contract
// - Bus or watchdog reset sets boot_state, clears both buffer enables and translation.
// - Control word bits 19:18, 13, 7:2 read zero; software writes zero.
// - Bits 31:28 maker code, 27:24 revision, fixed and read only.
// - soft_walk_traps turns table walks into instruction and data miss traps.
// - address_snoop_out drives phys_addr_latch 27:0 onto expansion address pins.
// - sbus_data_snoop_out mirrors internal memory data onto expansion data pins.
// - memory_data_snoop_out mirrors internal memory data onto memory data pins.
// - parity_sense zero selects even parity, one selects odd parity.
// - itlb_buffer_off stops use of instr_translation_latch.
// - Caches follow enables unless translation and alt_buffer_permit are both clear.
// - boot_state set on either reset; software clears it before normal work.
// - parity_check_on controls word parity checking; polarity is a parameter.
// - refresh_interval codes: 128 clocks, off, 512 clocks, 768 clocks.
// - A clear buffer enable makes every reference to that cache miss.
// - quiet_fault_mode suppresses supervisor exceptions, only recording sync_fault_status.
// - Translation off makes physical address the low 31 virtual bits.
// - address_space_number holds a 6-bit context; upper bits read zero.
// - Root pointer is root_table_base 22:4 at 26:8, context at 7:2.
// - root_table_base holds 19 bits at 22:4; other bits read zero.
// - Fault overwrite rules decide replacement and status_lost_flag.
// - Fault status select 0x03 reads clear, 0x13 reads keep and writes update.
`timescale 1ns/1ns
`default_nettype none
module mmu_control_registers
   import mmu_ctl_pkg::*;
#(
   parameter logic [3:0] MAKER_CODE = 4'ha, // Arbitrary value.
   parameter logic [3:0] REVISION = 4'h5, // Arbitrary value.
   parameter logic PARITY_ON_LEVEL = 1'b1
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic watchdog_rst,
   input wire logic asi_valid,
   input wire logic asi_write,
   input wire logic [7:0] alternate_space_id,
   input wire logic [4:0] asi_select,
   input wire logic [31:0] asi_wdata,
   output logic asi_ack,
   output logic [31:0] asi_rdata,
   input wire logic [31:0] virt_addr,
   input wire logic [30:0] translated_addr,
   output logic [30:0] physical_addr_bus,
   output logic [30:0] root_ptr_addr,
   output logic [5:0] context_out,
   input wire logic itlb_hit,
   output logic use_itlb_latch,
   input wire logic instr_tlb_miss,
   input wire logic data_tlb_miss,
   output logic instr_miss_trap,
   output logic data_miss_trap,
   output logic hw_walk_start,
   output logic icache_enable,
   output logic dcache_enable,
   input wire logic [27:0] phys_addr_latch,
   input wire logic [31:0] mem_data_bus,
   output logic [27:0] expansion_addr_out,
   output logic expansion_addr_oe,
   output logic [31:0] expansion_data_out,
   output logic expansion_data_oe,
   output logic [31:0] mem_data_out,
   output logic mem_data_oe,
   output logic expansion_bus_free,
   output logic load_store_allowed,
   input wire logic mem_data_valid,
   input wire logic mem_parity_in,
   output logic mem_parity_out,
   output logic parity_error,
   output logic refresh_req,
   input wire logic fault_valid,
   input wire logic fault_is_data,
   input wire logic fault_supervisor,
   input wire logic [31:1] fault_status_in,
   output logic fault_exception,
   output logic [31:0] sync_fault_status
);
   typedef enum {PEND_NONE, PEND_INSTR, PEND_DATA} pend_t;

   logic [31:0] ctrl;
   logic [31:0] address_space_number;
   logic [31:0] root_table_base;
   pend_t pend;
   logic hit_regs, ctrl_wr, root_wr, ctx_wr, fault_wr, fault_clr_rd;
   logic next_parity, next_perr, refresh_pulse;
   logic fault_take, instr_replace;

   always_comb
   begin
      hit_regs = asi_valid && alternate_space_id == ASI_MMU_REGS;
      ctrl_wr = hit_regs && asi_write && asi_select == SEL_CTRL;
      root_wr = hit_regs && asi_write && asi_select == SEL_ROOT;
      ctx_wr = hit_regs && asi_write && asi_select == SEL_CONTEXT;
      fault_wr = hit_regs && asi_write && asi_select == SEL_FAULT_KEEP;
      fault_clr_rd = hit_regs && !asi_write && asi_select == SEL_FAULT_CLR;
      instr_replace = fault_valid && !fault_is_data && pend != PEND_DATA;
      fault_take = fault_valid && (fault_is_data || instr_replace);
   end

   // Watchdog reset outranks a store in the same cycle.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         ctrl <= CTRL_RESET;
      else
      begin
         if (ctrl_wr)
            ctrl <= asi_wdata & CTRL_WMASK;
         if (watchdog_rst)
         begin
            ctrl[BOOT] <= 1'b1;
            ctrl[IBUF_ON] <= 1'b0;
            ctrl[OBUF_ON] <= 1'b0;
            ctrl[XLATE_ON] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         address_space_number <= 32'h00000000;
         root_table_base <= 32'h00000000;
      end
      else
      begin
         if (ctx_wr)
            address_space_number <= asi_wdata & CONTEXT_MASK;
         if (root_wr)
            root_table_base <= asi_wdata & ROOT_MASK;
      end
   end

   // A fault in the same cycle as a clearing read wins, so no status is lost.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         sync_fault_status <= 32'h00000000;
         pend <= PEND_NONE;
      end
      else if (fault_take)
      begin
         sync_fault_status[31:1] <= fault_status_in & FAULT_MASK[31:1];
         pend <= fault_is_data ? PEND_DATA : PEND_INSTR;
         if (fault_is_data)
            sync_fault_status[0] <= pend == PEND_DATA;
         else
            sync_fault_status[0] <= pend == PEND_INSTR;
      end
      else if (fault_clr_rd)
      begin
         sync_fault_status <= 32'h00000000;
         pend <= PEND_NONE;
      end
      else if (fault_wr)
         sync_fault_status <= asi_wdata & FAULT_MASK;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         asi_ack <= 1'b0;
         asi_rdata <= 32'h00000000;
      end
      else
      begin
         asi_ack <= asi_valid;
         asi_rdata <= 32'h00000000;
         if (hit_regs && !asi_write)
         begin
            case (asi_select)
               SEL_CTRL: asi_rdata <= {MAKER_CODE, REVISION, ctrl[23:0] & CTRL_WMASK[23:0]};
               SEL_ROOT: asi_rdata <= root_table_base;
               SEL_CONTEXT: asi_rdata <= address_space_number;
               SEL_FAULT_CLR, SEL_FAULT_KEEP: asi_rdata <= sync_fault_status;
               default: asi_rdata <= 32'h00000000;
            endcase
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         physical_addr_bus <= 31'h00000000;
         root_ptr_addr <= 31'h00000000;
         context_out <= 6'h00;
         use_itlb_latch <= 1'b0;
      end
      else
      begin
         physical_addr_bus <= ctrl[XLATE_ON] ? translated_addr : virt_addr[30:0];
         root_ptr_addr <= {4'h0, root_table_base[22:4], address_space_number[5:0], 2'b00};
         context_out <= address_space_number[5:0];
         use_itlb_latch <= itlb_hit && !ctrl[ITLB_OFF];
      end
   end

   // Miss handling and cache gating.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         instr_miss_trap <= 1'b0;
         data_miss_trap <= 1'b0;
         hw_walk_start <= 1'b0;
         icache_enable <= 1'b0;
         dcache_enable <= 1'b0;
      end
      else
      begin
         instr_miss_trap <= ctrl[SOFT_WALK] && instr_tlb_miss;
         data_miss_trap <= ctrl[SOFT_WALK] && data_tlb_miss;
         hw_walk_start <= !ctrl[SOFT_WALK] && (instr_tlb_miss || data_tlb_miss);
         icache_enable <= ctrl[IBUF_ON] && (ctrl[XLATE_ON] || ctrl[ALT_PERMIT]);
         dcache_enable <= ctrl[OBUF_ON] && (ctrl[XLATE_ON] || ctrl[ALT_PERMIT]);
      end
   end

   // Diagnostic snoop outputs; the pins idle at zero when not driven.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         expansion_addr_out <= 28'h0000000;
         expansion_addr_oe <= 1'b0;
         expansion_data_out <= 32'h00000000;
         expansion_data_oe <= 1'b0;
         mem_data_out <= 32'h00000000;
         mem_data_oe <= 1'b0;
         expansion_bus_free <= 1'b1;
         load_store_allowed <= 1'b1;
      end
      else
      begin
         expansion_addr_out <= ctrl[ADDR_SNOOP] ? phys_addr_latch : 28'h0000000;
         expansion_addr_oe <= ctrl[ADDR_SNOOP];
         expansion_data_out <= ctrl[SBUS_SNOOP] ? mem_data_bus : 32'h00000000;
         expansion_data_oe <= ctrl[SBUS_SNOOP];
         mem_data_out <= ctrl[MEM_SNOOP] ? mem_data_bus : 32'h00000000;
         mem_data_oe <= ctrl[MEM_SNOOP];
         expansion_bus_free <= !(ctrl[ADDR_SNOOP] || ctrl[SBUS_SNOOP]);
         load_store_allowed <= !ctrl[MEM_SNOOP];
      end
   end

   parity_unit parity_inst (
      .data(mem_data_bus),
      .parity_in(mem_parity_in),
      .odd_sense(ctrl[PARITY_SENSE]),
      .check_on(ctrl[PARITY_ON] == PARITY_ON_LEVEL),
      .check_valid(mem_data_valid),
      .parity_out(next_parity),
      .parity_error(next_perr)
   );

   refresh_timer refresh_inst (
      .clk(clk),
      .sys_rst(sys_rst),
      .interval(ctrl[REFRESH_LSB +: 2]),
      .refresh_req(refresh_pulse)
   );

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         mem_parity_out <= 1'b0;
         parity_error <= 1'b0;
         refresh_req <= 1'b0;
         fault_exception <= 1'b0;
      end
      else
      begin
         mem_parity_out <= next_parity;
         parity_error <= next_perr;
         refresh_req <= refresh_pulse;
         fault_exception <= fault_take && !(ctrl[QUIET_FAULT] && fault_supervisor);
      end
   end

   boot_on_wdog_a: assert property (@(posedge clk) disable iff (sys_rst)
      watchdog_rst |=> ctrl[BOOT] && !ctrl[XLATE_ON] && !ctrl[IBUF_ON] && !ctrl[OBUF_ON])
      else $error("Watchdog reset did not set boot state.");
   ctrl_reserved_a: assert property (@(posedge clk) disable iff (sys_rst)
      $past(hit_regs && !asi_write && asi_select == SEL_CTRL) |-> (asi_rdata & 32'h000c20fc) == 32'h00000000)
      else $error("Reserved control bits read nonzero.");
   ident_fixed_a: assert property (@(posedge clk) disable iff (sys_rst)
      $past(hit_regs && !asi_write && asi_select == SEL_CTRL) |-> asi_rdata[31:24] == {MAKER_CODE, REVISION})
      else $error("Identity fields changed.");
   soft_walk_a: assert property (@(posedge clk) disable iff (sys_rst)
      (ctrl[SOFT_WALK] && instr_tlb_miss) |=> instr_miss_trap && !hw_walk_start)
      else $error("Miss did not trap under software walk.");
   addr_snoop_a: assert property (@(posedge clk) disable iff (sys_rst)
      ctrl[ADDR_SNOOP] |=> expansion_addr_oe && !expansion_bus_free && expansion_addr_out == $past(phys_addr_latch))
      else $error("Address snoop not driven.");
   cache_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
      (!ctrl[XLATE_ON] && !ctrl[ALT_PERMIT]) |=> !icache_enable && !dcache_enable)
      else $error("Cache enabled with translation and permit clear.");
   pass_through_a: assert property (@(posedge clk) disable iff (sys_rst)
      !ctrl[XLATE_ON] |=> physical_addr_bus == $past(virt_addr[30:0]))
      else $error("Untranslated address mismatch.");
   root_ptr_a: assert property (@(posedge clk) disable iff (sys_rst)
      ##1 root_ptr_addr[26:2] == {$past(root_table_base[22:4]), $past(address_space_number[5:0])}
      && root_ptr_addr[30:27] == 4'h0 && root_ptr_addr[1:0] == 2'b00)
      else $error("Root pointer address malformed.");
   instr_overwrite_a: assert property (@(posedge clk) disable iff (sys_rst)
      (fault_valid && !fault_is_data && pend == PEND_INSTR) |=> sync_fault_status[0])
      else $error("Lost status flag not set.");
   fault_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
      (fault_clr_rd && !fault_take) |=> sync_fault_status == 32'h00000000 && asi_ack)
      else $error("Clearing read left status.");
endmodule : mmu_control_registers
`default_nettype wire

/* File: hdl/mmu_ctl_pkg.sv */
// Constants shared by the memory management unit control register set.
package mmu_ctl_pkg;
   // Alternate space and register select codes carried on address bits 12:8.
   localparam logic [7:0] ASI_MMU_REGS = 8'h04;
   localparam logic [4:0] SEL_CTRL = 5'h00;
   localparam logic [4:0] SEL_ROOT = 5'h01;
   localparam logic [4:0] SEL_CONTEXT = 5'h02;
   localparam logic [4:0] SEL_FAULT_CLR = 5'h03;
   localparam logic [4:0] SEL_FAULT_KEEP = 5'h13;
   // Control word field positions.
   localparam int MAKER_LSB = 28;
   localparam int REV_LSB = 24;
   localparam int SOFT_WALK = 23;
   localparam int ADDR_SNOOP = 22;
   localparam int SBUS_SNOOP = 21;
   localparam int MEM_SNOOP = 20;
   localparam int PARITY_SENSE = 17;
   localparam int ITLB_OFF = 16;
   localparam int ALT_PERMIT = 15;
   localparam int BOOT = 14;
   localparam int PARITY_ON = 12;
   localparam int REFRESH_LSB = 10;
   localparam int IBUF_ON = 9;
   localparam int OBUF_ON = 8;
   localparam int QUIET_FAULT = 1;
   localparam int XLATE_ON = 0;
   // Writable bits of the control word; identity and unimplemented bits are excluded.
   localparam logic [31:0] CTRL_WMASK = 32'h00f3df03;
   localparam logic [31:0] CTRL_RESET = 32'h00004000;
   localparam logic [31:0] CONTEXT_MASK = 32'h0000003f;
   localparam logic [31:0] ROOT_MASK = 32'h007ffff0;
   localparam logic [31:0] FAULT_MASK = 32'h00016fff;
   // Refresh interval codes and periods in clocks.
   localparam logic [1:0] REFRESH_128 = 2'b00;
   localparam logic [1:0] REFRESH_OFF = 2'b01;
   localparam logic [1:0] REFRESH_512 = 2'b10;
   localparam logic [9:0] PERIOD_128 = 10'd128;
   localparam logic [9:0] PERIOD_512 = 10'd512;
   localparam logic [9:0] PERIOD_768 = 10'd768;
endpackage : mmu_ctl_pkg

/* File: hdl/parity_unit.sv */
// Word parity generation and checking with selectable sense.
`timescale 1ns/1ns
`default_nettype none
module parity_unit
(
   input wire logic [31:0] data,
   input wire logic parity_in,
   input wire logic odd_sense,
   input wire logic check_on,
   input wire logic check_valid,
   output logic parity_out,
   output logic parity_error
);
   function automatic logic word_parity(input logic [31:0] w, input logic odd);
      word_parity = (^w) ^ odd;
   endfunction : word_parity

   always_comb
   begin
      parity_out = word_parity(data, odd_sense);
      parity_error = check_on && check_valid && (parity_in != word_parity(data, odd_sense));
   end
endmodule : parity_unit
`default_nettype wire

/* File: hdl/refresh_timer.sv */
// Memory refresh request generator driven by the refresh interval code.
`timescale 1ns/1ns
`default_nettype none
module refresh_timer
   import mmu_ctl_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [1:0] interval,
   output logic refresh_req
);
   logic [9:0] count;
   logic [9:0] period;

   always_comb
   begin
      case (interval)
         REFRESH_128: period = PERIOD_128;
         REFRESH_512: period = PERIOD_512;
         default: period = PERIOD_768;
      endcase
   end

   // Only the off code clears the count; any other change of code is compared against the running count at once.
   always_ff @(posedge clk)
   begin
      if (sys_rst || interval == REFRESH_OFF)
      begin
         count <= 10'h000;
         refresh_req <= 1'b0;
      end
      else if (count >= period - 10'd1)
      begin
         count <= 10'h000;
         refresh_req <= 1'b1;
      end
      else
      begin
         count <= count + 10'd1;
         refresh_req <= 1'b0;
      end
   end
endmodule : refresh_timer
`default_nettype wire

/* File: sim/iu_model.sv */
// Integer unit model that issues alternate space loads and stores to the register set.
`timescale 1ns/1ns
`default_nettype none
module iu_model
   import mmu_ctl_pkg::*;
(
   input wire logic clk,
   output logic asi_valid,
   output logic asi_write,
   output logic [7:0] alternate_space_id,
   output logic [4:0] asi_select,
   output logic [31:0] asi_wdata,
   input wire logic asi_ack,
   input wire logic [31:0] asi_rdata
);
   initial
   begin
      asi_valid = 1'b0;
      asi_write = 1'b0;
      alternate_space_id = 8'h00;
      asi_select = 5'h00;
      asi_wdata = 32'h0;
   end

   // One access is a single-cycle request followed by a bounded wait for the acknowledge.
   task automatic access(input logic wr, input logic [7:0] id, input logic [4:0] sel, input logic [31:0] wd,
      output logic [31:0] rd, output logic ok);
      int n;
      logic [31:0] data;
      n = 0;
      data = wd;
      if (wr && id == ASI_MMU_REGS && sel == SEL_CTRL)
         data = wd & ~32'h000c20fc;
      if (wr && id == ASI_MMU_REGS && sel == SEL_ROOT)
         data = wd & ROOT_MASK;
      if (wr && id == ASI_MMU_REGS && sel == SEL_CONTEXT)
         data = wd & CONTEXT_MASK;
      @(posedge clk);
      {asi_valid, asi_write, alternate_space_id, asi_select, asi_wdata} <= {1'b1, wr, id, sel, data};
      @(posedge clk);
      asi_valid <= 1'b0;
      // Released store data must not linger as a valid-looking word.
      asi_wdata <= ~data;
      @(posedge clk);
      while (asi_ack !== 1'b1 && n < 8)
         @(posedge clk) n++;
      rd = asi_rdata;
      ok = (asi_ack === 1'b1);
      if (wr)
         @(posedge clk);
   endtask : access
endmodule : iu_model
`default_nettype wire

/* File: sim/mmu_control_registers_tb.sv */
// Self-checking bench for the memory management unit control registers.
`timescale 1ns/1ns
`default_nettype none
module mmu_control_registers_tb
   import mmu_ctl_pkg::*;
;
   localparam logic [3:0] MAKER = 4'h6; // Arbitrary value.
   localparam logic [3:0] REV = 4'h3; // Arbitrary value.
   logic clk = 1'b0, sys_rst = 1'b1, watchdog_rst = 1'b0, itlb_hit = 1'b0, instr_tlb_miss = 1'b0;
   logic data_tlb_miss = 1'b0, mem_data_valid = 1'b0, mem_parity_in = 1'b0, fault_valid = 1'b0;
   logic fault_is_data = 1'b0, fault_supervisor = 1'b0;
   logic [31:0] virt_addr = 32'h0, mem_data_bus = 32'h0;
   logic [30:0] translated_addr = 31'h0, fault_status_in = 31'h0;
   logic [27:0] phys_addr_latch = 28'h0;
   logic asi_valid, asi_write, asi_ack, use_itlb_latch, instr_miss_trap, data_miss_trap, hw_walk_start;
   logic icache_enable, dcache_enable, expansion_addr_oe, expansion_data_oe, mem_data_oe, expansion_bus_free;
   logic load_store_allowed, mem_parity_out, parity_error, refresh_req, fault_exception, ok;
   logic [7:0] alternate_space_id;
   logic [4:0] asi_select;
   logic [31:0] asi_wdata, asi_rdata, expansion_data_out, mem_data_out, sync_fault_status, rd, r;
   logic [30:0] physical_addr_bus, root_ptr_addr;
   logic [27:0] expansion_addr_out;
   logic [5:0] context_out;
   logic [31:0] c_m = CTRL_RESET, root_m = 32'h0, ctx_m = 32'h0, fs_m = 32'h0, seed = 32'h75403332;
   int pend_m = 0, miscompares = 0, checks_done = 0;
   int period [4] = '{128, 512, 768, 0};
   logic [1:0] code [4] = '{2'b00, 2'b10, 2'b11, 2'b01};

   always #20 clk = ~clk;

   mmu_control_registers #(.MAKER_CODE(MAKER), .REVISION(REV), .PARITY_ON_LEVEL(1'b1)) dut_u (.*);

   iu_model iu_u (.clk(clk), .asi_valid(asi_valid), .asi_write(asi_write), .alternate_space_id(alternate_space_id),
      .asi_select(asi_select), .asi_wdata(asi_wdata), .asi_ack(asi_ack), .asi_rdata(asi_rdata));

   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction : rnd

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wrap_up();
      if (miscompares == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : wrap_up

   task automatic acc(input logic wr, input logic [4:0] sel, input logic [31:0] wd, input logic [7:0] id);
      iu_u.access(wr, id, sel, wd, rd, ok);
      chk("asi_ack", 32'h1, {31'h0, ok});
   endtask : acc

   task automatic reg_wr(input logic [4:0] sel, input logic [31:0] wd);
      acc(1'b1, sel, wd, ASI_MMU_REGS);
      if (sel == SEL_CTRL)
         c_m = wd & CTRL_WMASK;
      if (sel == SEL_ROOT)
         root_m = wd & ROOT_MASK;
      if (sel == SEL_CONTEXT)
         ctx_m = wd & CONTEXT_MASK;
      if (sel == SEL_FAULT_KEEP)
         fs_m = wd & FAULT_MASK;
   endtask : reg_wr

   task automatic reg_rd(input logic [4:0] sel, input logic [31:0] exp, input string what);
      acc(1'b0, sel, 32'h0, ASI_MMU_REGS);
      chk(what, exp, rd);
   endtask : reg_rd

   // Every output that follows the control word, except refresh_req and fault_exception, is compared with the bench model.
   task automatic chk_out();
      logic on, par;
      on = c_m[XLATE_ON] | c_m[ALT_PERMIT];
      par = ^mem_data_bus ^ c_m[PARITY_SENSE];
      #1;
      chk("caches", {c_m[IBUF_ON] & on, c_m[OBUF_ON] & on}, {icache_enable, dcache_enable});
      chk("phys", c_m[XLATE_ON] ? translated_addr : virt_addr[30:0], physical_addr_bus);
      chk("itlb", itlb_hit & ~c_m[ITLB_OFF], use_itlb_latch);
      chk("walk", {instr_tlb_miss & c_m[SOFT_WALK], data_tlb_miss & c_m[SOFT_WALK],
         (instr_tlb_miss | data_tlb_miss) & ~c_m[SOFT_WALK]}, {instr_miss_trap, data_miss_trap, hw_walk_start});
      chk("exp_addr", phys_addr_latch & {28{c_m[ADDR_SNOOP]}}, expansion_addr_out);
      chk("exp_data", mem_data_bus & {32{c_m[SBUS_SNOOP]}}, expansion_data_out);
      chk("mem_data", mem_data_bus & {32{c_m[MEM_SNOOP]}}, mem_data_out);
      chk("views", {c_m[ADDR_SNOOP], c_m[SBUS_SNOOP], c_m[MEM_SNOOP], ~(c_m[ADDR_SNOOP] | c_m[SBUS_SNOOP]),
         ~c_m[MEM_SNOOP]}, {expansion_addr_oe, expansion_data_oe, mem_data_oe, expansion_bus_free,
         load_store_allowed});
      chk("parity", {par, c_m[PARITY_ON] & mem_data_valid & (mem_parity_in != par)},
         {mem_parity_out, parity_error});
      chk("root_ptr", {4'h0, root_m[22:4], ctx_m[5:0], 2'b00}, root_ptr_addr);
      chk("context", ctx_m, context_out);
   endtask : chk_out

   task automatic meas(input int p);
      int n;
      n = 0;
      while (refresh_req !== 1'b1 && n < 1600)
         @(posedge clk) n++;
      n = 0;
      @(posedge clk);
      while (refresh_req !== 1'b1 && n < 1600)
         @(posedge clk) n++;
      // A period of zero stands for no refresh pulse at all within the search limit.
      chk("refresh_period", p, (refresh_req === 1'b1) ? n + 1 : 0);
   endtask : meas

   task automatic flt(input logic isd, input logic sup);
      logic [31:0] st;
      logic ign, exc;
      st = rnd();
      ign = !isd && pend_m == 2;
      exc = !(c_m[QUIET_FAULT] && sup);
      if (!ign)
         fs_m = ({st[31:1], 1'b0} & FAULT_MASK) | {31'h0, pend_m == (isd ? 2 : 1)};
      if (!ign)
         pend_m = isd ? 2 : 1;
      @(posedge clk);
      {fault_valid, fault_is_data, fault_supervisor, fault_status_in} <= {1'b1, isd, sup, st[31:1]};
      @(posedge clk);
      fault_valid <= 1'b0;
      fault_status_in <= ~st[31:1];
      #1;
      if (!ign)
         chk("fault_exc", exc, fault_exception);
      chk("fault_status", fs_m, sync_fault_status);
   endtask : flt

   initial
   begin
      #(40 * 30000);
      miscompares++;
      $display("ERROR watchdog expected finish seen timeout");
      wrap_up();
   end

   initial
   begin
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      reg_rd(SEL_CTRL, {MAKER, REV, CTRL_RESET[23:0]}, "ctrl_reset");
      reg_rd(SEL_FAULT_KEEP, 32'h0, "fault_reset");
      acc(1'b1, SEL_CTRL, 32'h00000301, 8'h05);
      acc(1'b0, 5'h07, 32'h0, ASI_MMU_REGS);
      chk("unmapped", 32'h0, rd);
      reg_rd(SEL_CTRL, {MAKER, REV, CTRL_RESET[23:0]}, "foreign_store");
      for (int i = 0; i < 24; i++)
      begin
         @(posedge clk);
         r = rnd();
         {itlb_hit, instr_tlb_miss, data_tlb_miss, mem_data_valid, mem_parity_in} <= r[4:0];
         translated_addr <= r[31:1];
         virt_addr <= rnd();
         mem_data_bus <= rnd();
         r = rnd();
         phys_addr_latch <= r[27:0];
         reg_wr(SEL_CTRL, (rnd() & ~32'h00008301) | {16'h0, i[3], 5'h0, i[2:1], 7'h0, i[0]});
         reg_wr(SEL_ROOT, rnd());
         reg_wr(SEL_CONTEXT, rnd());
         reg_rd(SEL_CTRL, {MAKER, REV, c_m[23:0]}, "ctrl_word");
         reg_rd(SEL_ROOT, root_m, "root_base");
         reg_rd(SEL_CONTEXT, ctx_m, "context_reg");
         chk_out();
      end
      reg_wr(SEL_CTRL, 32'h00f38f03);
      @(posedge clk);
      watchdog_rst <= 1'b1;
      @(posedge clk);
      watchdog_rst <= 1'b0;
      c_m = (c_m | 32'h00004000) & ~32'h00000301;
      reg_rd(SEL_CTRL, {MAKER, REV, c_m[23:0]}, "ctrl_watchdog");
      reg_rd(SEL_ROOT, root_m, "root_watchdog");
      chk_out();
      for (int k = 0; k < 4; k++)
      begin
         reg_wr(SEL_CTRL, {20'h0, code[k], 10'h0});
         meas(period[k]);
      end
      reg_wr(SEL_CTRL, 32'h0);
      flt(1'b0, 1'b1);
      flt(1'b0, 1'b1);
      flt(1'b1, 1'b0);
      flt(1'b0, 1'b0);
      flt(1'b1, 1'b1);
      reg_rd(SEL_FAULT_KEEP, fs_m, "fault_keep");
      reg_rd(SEL_FAULT_CLR, fs_m, "fault_clear");
      fs_m = 32'h0;
      pend_m = 0;
      reg_rd(SEL_FAULT_KEEP, 32'h0, "fault_cleared");
      acc(1'b1, SEL_FAULT_CLR, 32'h00016ffe, ASI_MMU_REGS);
      reg_rd(SEL_FAULT_KEEP, 32'h0, "fault_store_ignored");
      reg_wr(SEL_FAULT_KEEP, 32'h00016ffe);
      reg_rd(SEL_FAULT_KEEP, fs_m, "fault_store");
      reg_wr(SEL_CTRL, 32'h00000002);
      flt(1'b1, 1'b1);
      flt(1'b1, 1'b0);
      wrap_up();
   end
endmodule : mmu_control_registers_tb
`default_nettype wire
